/* design/lwic_pkg.sv */
// Constants for the link width and initialization control register bank
package lwic_pkg;

    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] ADDR_SIDE_A      = 12'h0c4;
    localparam logic [11:0] ADDR_SIDE_B      = 12'h0c8;

    // ==================================================================
    // Field positions
    localparam int          OUT_LSB          = 28;
    localparam int          IN_LSB           = 24;
    localparam int          MAX_OUT_LSB      = 20;
    localparam int          MAX_IN_LSB       = 16;
    localparam int          HOLD_BIT         = 14;
    localparam int          DONE_BIT         = 5;

    // ==================================================================
    // Width encodings
    localparam logic [2:0]  WIDTH_8          = 3'h0;
    localparam logic [2:0]  WIDTH_16         = 3'h1;
    localparam logic [2:0]  WIDTH_4          = 3'h5;
    localparam logic [2:0]  WIDTH_2          = 3'h4;
    localparam logic [2:0]  WIDTH_NC         = 3'h7;
    localparam logic [2:0]  MAX_WIDTH_A      = WIDTH_16;
    localparam logic [2:0]  MAX_WIDTH_B      = WIDTH_8;

    // ==================================================================
    // Values after power-good reset
    localparam logic [2:0]  WIDTH_RST        = 3'h0;
    localparam logic        HOLD_RST         = 1'b0;

    // ==================================================================
    // Control line hold times; one bit time is taken as one link clock
    localparam int          SHORT_HOLD_BITS  = 16;
    localparam int          SHORT_HOLD_CYC   = SHORT_HOLD_BITS;
    localparam int          LONG_HOLD_NS     = 50000;
    localparam int          LINK_PERIOD_PS   = 6000;
    localparam int          LONG_HOLD_CYC    = (LONG_HOLD_NS * 1000) / LINK_PERIOD_PS;
    localparam int          CNT_W            = 14;

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_WAIT_RX,
        LK_HOLD,
        LK_UP,
        LK_DISC
    } lwic_lstate_type;

endpackage : lwic_pkg

/* design/lwic_top.sv */
// APB register bank and per-side link initialization control
`timescale 1ns/1ps
`default_nettype none

module lwic_top #(
    parameter int LONG_HOLD_CYC_P = lwic_pkg::LONG_HOLD_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  pce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  link_clk,
    input  wire logic                  link_reset_n,
    input  wire logic                  link_stop_n,
    input  wire logic [1:0]            rx_control_line,
    input  wire logic [1:0][2:0]       peer_rx_max,
    input  wire logic [1:0][2:0]       peer_tx_max,
    output logic      [1:0]            tx_control_line,
    output logic      [1:0]            init_done,
    output logic      [1:0][2:0]       out_width_now,
    output logic      [1:0][2:0]       in_width_now
);
    import lwic_pkg::*;

    // ==================================================================
    // State
    typedef struct packed {
        logic [1:0][2:0] out_width_sel;
        logic [1:0][2:0] in_width_sel;
        logic [1:0]      long_ctl_hold;
        logic            prime;
        logic            prime2;
        logic            loaded;
        logic            cfg_tog;
        logic [1:0]      done_s1;
        logic [1:0]      done_s2;
        logic [11:0]     peer_s1;
        logic [11:0]     peer_s2;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } lwic_pstate_type;

    typedef struct packed {
        logic                       tog_s1;
        logic                       tog_s2;
        logic                       tog_s3;
        logic [13:0]                shadow;
        logic                       rst_s1;
        logic                       rst_s2;
        logic                       stop_s1;
        logic                       stop_s2;
        logic [1:0]                 rx_s1;
        logic [1:0]                 rx_s2;
        lwic_lstate_type [1:0]      st;
        logic [1:0][CNT_W-1:0]      cnt;
        logic [1:0]                 after_stop;
        logic [1:0]                 tx;
        logic [1:0]                 done;
        logic [1:0][2:0]            act_out;
        logic [1:0][2:0]            act_in;
        logic                       shadow_ok;
    } lwic_lstate_all_type;

    lwic_pstate_type     p_ff;
    lwic_pstate_type     nxt_p;
    lwic_lstate_all_type l_ff;
    lwic_lstate_all_type nxt_l;

    localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(LONG_HOLD_CYC_P - 1);

    function automatic logic width_legal(input logic [2:0] code, input int side);
        width_legal = (code == WIDTH_8) || (code == WIDTH_4) || (code == WIDTH_2)
                   || (code == WIDTH_NC) || ((code == WIDTH_16) && (side == 0));
    endfunction : width_legal

    function automatic logic [2:0] width_rank(input logic [2:0] code);
        case (code)
            WIDTH_2:  width_rank = 3'h1;
            WIDTH_4:  width_rank = 3'h2;
            WIDTH_8:  width_rank = 3'h3;
            WIDTH_16: width_rank = 3'h4;
            default:  width_rank = 3'h0;
        endcase
    endfunction : width_rank

    // Narrower of own limit and peer limit; a peer that is absent gives no link
    function automatic logic [2:0] width_min(input logic [2:0] a, input logic [2:0] b);
        width_min = (width_rank(a) <= width_rank(b)) ? a : b;
        if (width_rank(width_min) == 3'h0) begin
            width_min = WIDTH_NC;
        end
    endfunction : width_min

    // ==================================================================
    // APB side
    logic        hit_a;
    logic        hit_b;
    logic        access;
    logic [31:0] rd_word;

    assign hit_a  = (paddr == ADDR_SIDE_A);
    assign hit_b  = (paddr == ADDR_SIDE_B);
    assign access = psel && penable && p_ff.pready;

    always_comb begin
        nxt_p          = p_ff;
        rd_word        = 32'h0000_0000;
        nxt_p.peer_s1  = {peer_tx_max, peer_rx_max};
        nxt_p.peer_s2  = p_ff.peer_s1;
        nxt_p.done_s1  = l_ff.done;
        nxt_p.done_s2  = p_ff.done_s1;
        nxt_p.prime    = 1'b1;
        nxt_p.prime2   = p_ff.prime;
        // negotiate once, after both peer sync stages hold pin values
        if (p_ff.prime2 && !p_ff.loaded) begin
            nxt_p.loaded  = 1'b1;
            nxt_p.cfg_tog = !p_ff.cfg_tog;
            for (int s = 0; s < 2; s++) begin
                nxt_p.out_width_sel[s] = width_min(s == 0 ? MAX_WIDTH_A : MAX_WIDTH_B,
                                                   p_ff.peer_s2[3*s +: 3]);
                nxt_p.in_width_sel[s]  = width_min(s == 0 ? MAX_WIDTH_A : MAX_WIDTH_B,
                                                   p_ff.peer_s2[6 + 3*s +: 3]);
            end
        end
        for (int s = 0; s < 2; s++) begin
            if ((s == 0) ? hit_a : hit_b) begin
                rd_word[OUT_LSB +: 3]     = p_ff.out_width_sel[s];
                rd_word[IN_LSB +: 3]      = p_ff.in_width_sel[s];
                rd_word[MAX_OUT_LSB +: 3] = (s == 0) ? MAX_WIDTH_A : MAX_WIDTH_B;
                rd_word[MAX_IN_LSB +: 3]  = (s == 0) ? MAX_WIDTH_A : MAX_WIDTH_B;
                rd_word[HOLD_BIT]         = p_ff.long_ctl_hold[s];
                rd_word[DONE_BIT]         = p_ff.done_s2[s];
                if (access && pwrite) begin
                    if (pstrb[3] && width_legal(pwdata[OUT_LSB +: 3], s)) begin
                        nxt_p.out_width_sel[s] = pwdata[OUT_LSB +: 3];
                    end
                    if (pstrb[3] && width_legal(pwdata[IN_LSB +: 3], s)) begin
                        nxt_p.in_width_sel[s] = pwdata[IN_LSB +: 3];
                    end
                    if (pstrb[1]) begin
                        nxt_p.long_ctl_hold[s] = pwdata[HOLD_BIT];
                    end
                end
            end
        end
        // Any change is flagged to the link domain, which samples after settling
        if ({nxt_p.out_width_sel, nxt_p.in_width_sel, nxt_p.long_ctl_hold}
            != {p_ff.out_width_sel, p_ff.in_width_sel, p_ff.long_ctl_hold}) begin
            nxt_p.cfg_tog = !p_ff.cfg_tog;
        end
        // One wait state: data and error are ready when pready rises
        nxt_p.pready = psel && penable && !p_ff.pready;
        if (psel && penable && !p_ff.pready) begin
            nxt_p.pslverr = !(hit_a || hit_b);
            nxt_p.prdata  = pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    // only power-good reset clears the fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_ff               <= '0;
            p_ff.out_width_sel <= {WIDTH_RST, WIDTH_RST};
            p_ff.in_width_sel  <= {WIDTH_RST, WIDTH_RST};
            p_ff.long_ctl_hold <= {HOLD_RST, HOLD_RST};
        end else if (pce) begin
            p_ff <= nxt_p;
        end
    end

    // ==================================================================
    // Link side
    always_comb begin
        nxt_l         = l_ff;
        nxt_l.tog_s1  = p_ff.cfg_tog;
        nxt_l.tog_s2  = l_ff.tog_s1;
        nxt_l.tog_s3  = l_ff.tog_s2;
        nxt_l.rst_s1  = link_reset_n;
        nxt_l.rst_s2  = l_ff.rst_s1;
        nxt_l.stop_s1 = link_stop_n;
        nxt_l.stop_s2 = l_ff.stop_s1;
        nxt_l.rx_s1   = rx_control_line;
        nxt_l.rx_s2   = l_ff.rx_s1;
        if (l_ff.tog_s3 != l_ff.tog_s2) begin
            nxt_l.shadow    = {p_ff.out_width_sel, p_ff.in_width_sel, p_ff.long_ctl_hold};
            nxt_l.shadow_ok = 1'b1;
        end
        for (int s = 0; s < 2; s++) begin
            case (l_ff.st[s])
                LK_IDLE: begin
                    nxt_l.tx[s] = 1'b0;
                    // No start before the negotiated widths reach the shadow
                    if (l_ff.rst_s2 && l_ff.stop_s2 && l_ff.shadow_ok) begin
                        nxt_l.act_out[s] = l_ff.shadow[8 + 3*s +: 3];
                        nxt_l.act_in[s]  = l_ff.shadow[2 + 3*s +: 3];
                        nxt_l.tx[s]      = 1'b1;
                        nxt_l.st[s]      = LK_WAIT_RX;
                    end
                end
                LK_WAIT_RX: begin
                    if (l_ff.rx_s2[s]) begin
                        nxt_l.cnt[s] = (l_ff.after_stop[s] && l_ff.shadow[s])
                                     ? LONG_LOAD : SHORT_LOAD;
                        nxt_l.st[s]  = LK_HOLD;
                    end
                end
                LK_HOLD: begin
                    nxt_l.cnt[s] = l_ff.cnt[s] - CNT_W'(1);
                    if (l_ff.cnt[s] == '0) begin
                        nxt_l.done[s] = 1'b1;
                        nxt_l.st[s]   = LK_UP;
                    end
                end
                LK_UP: begin
                    if (!l_ff.stop_s2) begin
                        nxt_l.tx[s] = 1'b0;
                        nxt_l.st[s] = LK_DISC;
                    end
                end
                LK_DISC: begin
                    nxt_l.done[s]       = 1'b0;
                    nxt_l.after_stop[s] = 1'b1;
                    nxt_l.st[s]         = LK_IDLE;
                end
                default: begin
                    nxt_l.st[s] = LK_IDLE;
                end
            endcase
            if (!l_ff.rst_s2) begin
                nxt_l.st[s]         = LK_IDLE;
                nxt_l.done[s]       = 1'b0;
                nxt_l.tx[s]         = 1'b0;
                nxt_l.after_stop[s] = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    assign prdata          = p_ff.prdata;
    assign pready          = p_ff.pready;
    assign pslverr         = p_ff.pslverr;
    assign tx_control_line = l_ff.tx;
    assign init_done       = l_ff.done;
    assign out_width_now   = l_ff.act_out;
    assign in_width_now    = l_ff.act_in;

    // ==================================================================
    // Checks
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && psel && penable && !pready |=> pready)
        else $error("access not answered");
    rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> (prdata[31] | prdata[27] | prdata[23] | prdata[19] | prdata[15]) == 1'b0)
        else $error("reserved bit read as one");
    max_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pslverr && !$past(pwrite) && $past(hit_a)
        |-> prdata[22:20] == WIDTH_16 && prdata[18:16] == WIDTH_16)
        else $error("side A max width wrong");
    side_b_16_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && access && pwrite && hit_b && pwdata[30:28] == WIDTH_16
        |=> p_ff.out_width_sel[1] == $past(p_ff.out_width_sel[1]))
        else $error("side B took 16-bit code");
    in_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && access && pwrite && hit_a && pstrb[3] && pwdata[26:24] == WIDTH_4
        |=> p_ff.in_width_sel[0] == WIDTH_4)
        else $error("in width write lost");
    width_apply_a: assert property (@(posedge link_clk) disable iff (!presetn)
        l_ff.st[0] != LK_IDLE |=> $stable(l_ff.act_out[0]) && $stable(l_ff.act_in[0]))
        else $error("width changed while link running");
    done_clear_a: assert property (@(posedge link_clk) disable iff (!presetn)
        !l_ff.rst_s2 |=> !init_done[0] && !init_done[1])
        else $error("init done kept over link reset");
    done_set_a: assert property (@(posedge link_clk) disable iff (!presetn)
        $rose(init_done[0]) |-> $past(l_ff.st[0]) == LK_HOLD && $past(l_ff.cnt[0]) == '0)
        else $error("init done rose without hold end");
    short_hold_a: assert property (@(posedge link_clk) disable iff (!presetn)
        l_ff.rst_s2 && l_ff.st[1] == LK_WAIT_RX && l_ff.rx_s2[1] && !l_ff.after_stop[1]
        |=> l_ff.cnt[1] == SHORT_LOAD)
        else $error("short hold count wrong");

    write_a_c: cover property (@(posedge pclk) access && pwrite && hit_a);
    read_b_c:  cover property (@(posedge pclk) access && !pwrite && hit_b);
    long_c:    cover property (@(posedge link_clk) l_ff.st[0] == LK_HOLD && l_ff.cnt[0] == LONG_LOAD);
    disc_c:    cover property (@(posedge link_clk) l_ff.st[0] == LK_DISC);

endmodule : lwic_top

`default_nettype wire

/* dv/lwic_peer.sv */
// Neighbouring link device: answers the transmit control line per side
`timescale 1ns/1ps
`default_nettype none
module lwic_peer (
    input  wire logic       link_clk,
    input  wire logic       presetn,
    input  wire logic [3:0] dly,
    input  wire logic [1:0] tx_control_line,
    output logic      [1:0] rx_control_line
);
    logic [1:0][3:0] cnt_ff;

    // ==============================================================
    // Answer after dly link clocks; drops at once when tx falls, so a
    // stale receive level never outlives the transmit request
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff          <= '0;
            rx_control_line <= '0;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (!tx_control_line[s]) begin
                    cnt_ff[s]          <= '0;
                    rx_control_line[s] <= 1'b0;
                end else if (cnt_ff[s] < dly) begin
                    cnt_ff[s] <= cnt_ff[s] + 4'h1;
                end else begin
                    rx_control_line[s] <= 1'b1;
                end
            end
        end
    end
endmodule : lwic_peer
`default_nettype wire

/* dv/link_width_init_control_tb.sv */
// Self-checking bench for the link width and initialization control bank
`timescale 1ns/1ps
`default_nettype none
module link_width_init_control_tb;
    import lwic_pkg::*;
    localparam int LONG = 60;
    logic            pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      pstrb, dly;
    logic            link_clk, link_reset_n, link_stop_n, err;
    logic [1:0]      rx_control_line, tx_control_line, init_done;
    logic [1:0][2:0] peer_rx_max, peer_tx_max, out_width_now, in_width_now;
    logic [2:0]      exp_out [2], exp_in [2], op_out [2], op_in [2];
    logic            exp_hold [2];
    logic [2:0]      codes [4] = '{WIDTH_16, WIDTH_8, WIDTH_4, WIDTH_2};
    int              span [2];
    int              mismatches, checks_done, seed;

    lwic_top #(.LONG_HOLD_CYC_P(LONG)) i_dut (.pclk, .presetn, .pce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_clk,
        .link_reset_n, .link_stop_n, .rx_control_line, .peer_rx_max, .peer_tx_max,
        .tx_control_line, .init_done, .out_width_now, .in_width_now);
    lwic_peer i_peer (.link_clk, .presetn, .dly, .tx_control_line, .rx_control_line);

    // ==============================================================
    // Clocks; link clock offset so the two never line up
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    // Link clocks with tx high before init completes
    always @(posedge link_clk) begin
        foreach (span[s]) begin
            if (!tx_control_line[s]) span[s] <= 0;
            else if (!init_done[s]) span[s] <= span[s] + 1;
        end
    end

    // ==============================================================
    // Expectations
    function automatic int rank(logic [2:0] c);
        case (c)
            WIDTH_16: return 4;
            WIDTH_8:  return 3;
            WIDTH_4:  return 2;
            WIDTH_2:  return 1;
            default:  return 0;
        endcase
    endfunction : rank
    function automatic logic [2:0] nego(logic [2:0] own, logic [2:0] peer);
        if (rank(peer) == 0) return WIDTH_NC;
        return (rank(peer) < rank(own)) ? peer : own;
    endfunction : nego
    function automatic logic legal(logic [2:0] c, int s);
        return (rank(c) != 0 || c == WIDTH_NC) && (c != WIDTH_16 || s == 0);
    endfunction : legal
    function automatic logic [31:0] reg_val(int s, logic done);
        logic [2:0] mx;
        mx = (s == 0) ? MAX_WIDTH_A : MAX_WIDTH_B;
        return {1'b0, exp_out[s], 1'b0, exp_in[s], 1'b0, mx, 1'b0, mx, 1'b0,
                exp_hold[s], 8'h00, done, 5'h00};
    endfunction : reg_val

    // ==============================================================
    // Tasks
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, logic [3:0] st);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) mismatches++;
    endtask : apb
    task automatic rd_side(int s, logic done);
        apb(1'b0, (s != 0) ? ADDR_SIDE_B : ADDR_SIDE_A, '0, '0);
        check("read_data", rd, reg_val(s, done));
        check("read_err", err, 0);
    endtask : rd_side
    task automatic wr_side(int s, logic [31:0] wd, logic [3:0] st);
        apb(1'b1, (s != 0) ? ADDR_SIDE_B : ADDR_SIDE_A, wd, st);
        if (st[3] && legal(wd[30:28], s)) exp_out[s] = wd[30:28];
        if (st[3] && legal(wd[26:24], s)) exp_in[s] = wd[26:24];
        if (st[1]) exp_hold[s] = wd[14];
        rd_side(s, 1'b1);
    endtask : wr_side
    task automatic wait_init(int ha, int hb);
        int n;
        n = 0;
        while (init_done !== 2'b11 && n < 2000) begin
            @(posedge link_clk);
            n++;
        end
        check("init_done", init_done, 2'b11);
        check("hold_a", span[0] >= ha + dly && span[0] <= ha + dly + 8, 1);
        check("hold_b", span[1] >= hb + dly && span[1] <= hb + dly + 8, 1);
        foreach (op_out[s]) begin
            check("out_now", out_width_now[s], op_out[s]);
            check("in_now", in_width_now[s], op_in[s]);
        end
    endtask : wait_init
    task automatic link_down;
        repeat (8) @(posedge pclk);
        check("down_done", init_done, 2'b00);
        check("down_tx", tx_control_line, 2'b00);
        rd_side(0, 1'b0);
        rd_side(1, 1'b0);
    endtask : link_down
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ==============================================================
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end

    // ==============================================================
    // Main sequence
    initial begin
        seed = 32'h25f5;
        {pce, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        pce = 1'b1;
        presetn = 1'b0;
        link_reset_n = 1'b1;
        link_stop_n = 1'b1;
        dly = 4'h2;
        mismatches = 0;
        checks_done = 0;
        foreach (codes[s]) begin
            if (s < 2) peer_rx_max[s] = codes[$unsigned($random(seed)) % 4];
            if (s < 2) peer_tx_max[s] = codes[$unsigned($random(seed)) % 4];
        end
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (exp_out[s]) begin
            exp_out[s] = nego(s ? WIDTH_8 : WIDTH_16, peer_rx_max[s]);
            exp_in[s] = nego(s ? WIDTH_8 : WIDTH_16, peer_tx_max[s]);
            exp_hold[s] = HOLD_RST;
            op_out[s] = exp_out[s];
            op_in[s] = exp_in[s];
        end
        repeat (3) @(posedge pclk);
        wait_init(SHORT_HOLD_CYC, SHORT_HOLD_CYC);
        rd_side(0, 1'b1);
        rd_side(1, 1'b1);
        repeat (8) wr_side($random(seed) & 1, $random(seed), $random(seed));
        wr_side(1, 32'h9900_4000, 4'hf);
        wr_side(0, 32'h5500_4000, 4'hf);
        wr_side(1, 32'h4500_0000, 4'hf);
        apb(1'b1, 12'h0cc, 32'hffff_ffff, 4'hf);
        check("bad_wr_err", err, 1);
        fork
            apb(1'b0, 12'h0d0, '0, '0);
            begin
                @(posedge pclk);
                pce <= 1'b0;
                repeat (3) @(posedge pclk);
                pce <= 1'b1;
            end
        join
        check("bad_rd_err", err, 1);
        check("bad_rd_data", rd, 0);
        rd_side(0, 1'b1);
        rd_side(1, 1'b1);
        foreach (op_out[s]) check("kept_now", out_width_now[s], op_out[s]);
        // Link reset: registers kept, first init after it uses the short hold
        @(posedge link_clk);
        link_reset_n <= 1'b0;
        link_down();
        @(posedge link_clk);
        link_reset_n <= 1'b1;
        op_out = exp_out;
        op_in = exp_in;
        wait_init(SHORT_HOLD_CYC, SHORT_HOLD_CYC);
        wr_side(0, 32'h0000_4000, 4'hf);
        wr_side(1, 32'h5500_0000, 4'hf);
        repeat (20) @(posedge pclk);
        // Link stop with a slow peer: side A now takes the long hold
        @(posedge link_clk);
        dly <= 4'h9;
        link_stop_n <= 1'b0;
        link_down();
        @(posedge link_clk);
        link_stop_n <= 1'b1;
        op_out = exp_out;
        op_in = exp_in;
        wait_init(LONG, SHORT_HOLD_CYC);
        rd_side(0, 1'b1);
        report_and_stop();
    end
endmodule : link_width_init_control_tb
`default_nettype wire
